// [hdl/pqs_top.sv]
// packet queues with a shared pool and a rate-profile priority scheduler
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module pqs_top #(
   parameter int NUM_IN = 2,   // scheduler inputs, one queue each
   parameter int QDEPTH = 16,  // descriptor slots per queue
   parameter int POOL   = 24   // shared buffer pool, in packets
) (
   input  wire logic                          sys_clk_in,     // system clock
   input  wire logic                          srst_in,        // sync reset, high
   input  wire pqs_pkg::pqs_reg_req_t         reg_in,         // register request
   output logic [pqs_pkg::DATA_W-1:0]         rd_data_out,    // read data, cycle after rd
   input  wire logic [NUM_IN-1:0]             enq_valid_in,   // enqueue strobe per input
   input  wire pqs_pkg::pqs_pkt_t [NUM_IN-1:0] enq_pkt_in,    // packet per input
   output logic [NUM_IN-1:0]                  enq_ready_out,  // queue will accept
   input  wire logic [NUM_IN-1:0]             drop_head_in,   // head dropper removal
   output logic                               deq_valid_out,  // packet on output
   output pqs_pkg::pqs_pkt_t                  deq_pkt_out,    // departing packet
   output logic [$clog2(NUM_IN)-1:0]          deq_src_out,    // input it came from
   input  wire logic                          out_ready_in,   // link takes packet
   output logic [NUM_IN-1:0]                  nonempty_out,   // queue holds packets
   output logic [NUM_IN-1:0][$clog2(QDEPTH):0] depth_pkt_out, // depth in packets
   output logic [NUM_IN-1:0][pqs_pkg::LEN_W+$clog2(QDEPTH):0] depth_byt_out, // bytes
   output logic [NUM_IN-1:0]                  thr_out,        // byte depth over threshold
   output logic                               pool_thr_out    // pool use at threshold
);
   localparam int AW  = $clog2(QDEPTH);
   localparam int IW  = $clog2(NUM_IN);
   localparam int BW  = pqs_pkg::LEN_W + AW + 1;
   localparam int PW  = $clog2(POOL + 1);
   localparam int LW  = pqs_pkg::LEN_W;
   localparam int TW  = pqs_pkg::TOK_W;
   localparam int RW  = pqs_pkg::RATE_W;
   localparam int PRW = pqs_pkg::PRIO_W;
   localparam int TCW = $clog2(pqs_pkg::TICK_CYC + 1);

   // ---------------------------------------------------------------
   // parameter checks
   // ---------------------------------------------------------------
   if (NUM_IN < 2 || NUM_IN > 6) begin : g_bad_num_in
      $error("NUM_IN must lie between 2 and 6");
   end
   if (QDEPTH < 2 || (1 << AW) != QDEPTH) begin : g_bad_qdepth
      $error("QDEPTH must be a power of two of at least 2");
   end
   if (POOL < NUM_IN) begin : g_bad_pool
      $error("POOL must be at least NUM_IN");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   // all state in one record: the comb block builds the next copy
   // and one flop bank holds it, so no field drifts out of step
   typedef struct packed {
      pqs_pkg::pqs_pkt_t [NUM_IN-1:0][QDEPTH-1:0] mem;
      logic [NUM_IN-1:0][AW-1:0]  wp;
      logic [NUM_IN-1:0][AW-1:0]  rp;
      logic [NUM_IN-1:0][AW:0]    cnt;
      logic [NUM_IN-1:0][BW-1:0]  byt;
      logic [PW-1:0]              pool_used;
      logic [PW-1:0]              pool_thr;
      logic [NUM_IN-1:0][RW-1:0]  min_rate;
      logic [NUM_IN-1:0][TW-1:0]  min_burst;
      logic [NUM_IN-1:0][RW-1:0]  max_rate;
      logic [NUM_IN-1:0][TW-1:0]  max_burst;
      logic [NUM_IN-1:0][PRW-1:0] prio;
      logic [NUM_IN-1:0][BW-1:0]  depth_thr;
      logic [NUM_IN-1:0][TW-1:0]  min_tok;
      logic [NUM_IN-1:0][TW-1:0]  max_tok;
      logic [1:0]                 ctrl;
      logic [TCW-1:0]             tick_cnt;
      logic [IW-1:0]              rr_last;
      logic                       ov;
      pqs_pkg::pqs_pkt_t          opkt;
      logic [IW-1:0]              osrc;
      logic [pqs_pkg::DATA_W-1:0] rdata;
      logic [NUM_IN-1:0]          ready;
      logic [NUM_IN-1:0]          nonempty;
      logic [NUM_IN-1:0]          thr;
      logic                       pthr;
   } pqs_state_t;

   pqs_state_t st_q;
   pqs_state_t st_d;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // round-robin pick: first requester after the last served input
   // scanning down and keeping the last hit leaves the nearest one
   function automatic logic [IW:0] rr_pick(input logic [NUM_IN-1:0] req, input logic [IW-1:0] last);
      logic [IW:0] res;
      int          j;
      res = '0;
      for (int k = NUM_IN; k >= 1; k--) begin
         j = int'(last) + k;
         if (j >= NUM_IN) begin
            j = j - NUM_IN;
         end
         if (req[j]) begin
            res = {1'b1, IW'(j)};
         end
      end
      return res;
   endfunction

   // register decode: {per-input hit, input index, field offset}
   function automatic logic [IW+5:0] reg_sel(input logic [pqs_pkg::ADDR_W-1:0] addr);
      logic [IW+5:0]             res;
      logic [pqs_pkg::ADDR_W-1:0] rel;
      res = '0;
      for (int i = 0; i < NUM_IN; i++) begin
         rel = addr - pqs_pkg::IN_BASE_OFS - pqs_pkg::ADDR_W'(i * int'(pqs_pkg::IN_STRIDE));
         if (addr >= pqs_pkg::IN_BASE_OFS && rel < pqs_pkg::IN_STRIDE) begin
            res = {1'b1, IW'(i), rel[4:0]};
         end
      end
      return res;
   endfunction

   // saturating add of a rate to a bucket, capped at its burst
   function automatic logic [TW-1:0] tok_fill(input logic [TW-1:0] tok, input logic [RW-1:0] rate,
                                              input logic [TW-1:0] burst);
      logic [TW:0] sum;
      sum = {1'b0, tok} + (TW+1)'(rate);
      return (sum > {1'b0, burst}) ? burst : sum[TW-1:0];
   endfunction

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      logic                      tick;
      logic                      nwc;
      logic [NUM_IN-1:0]         ne;
      logic [NUM_IN-1:0]         min_ok;
      logic [NUM_IN-1:0]         max_ok;
      logic [NUM_IN-1:0]         req_min;
      logic [NUM_IN-1:0]         req_left;
      logic [NUM_IN-1:0]         req_prio;
      logic [NUM_IN-1:0][LW-1:0] hlen;
      logic [NUM_IN-1:0]         pop;
      logic [PRW-1:0]            best;
      logic [IW:0]               pick;
      logic                      from_min;
      logic                      slot;
      logic [IW+5:0]             sel;
      logic [IW-1:0]             si;
      logic [pqs_pkg::DATA_W-1:0] wd;
      logic [PW-1:0]             pool_n;
      tick     = 1'b0;
      nwc      = st_q.ctrl[pqs_pkg::CTRL_NWC_BIT];
      ne       = '0;
      min_ok   = '0;
      max_ok   = '0;
      hlen     = '0;
      pop      = '0;
      best     = '1;
      pick     = '0;
      from_min = 1'b0;
      slot     = 1'b0;
      req_min  = '0;
      req_left = '0;
      req_prio = '0;
      sel      = '0;
      si       = '0;
      wd       = reg_in.wdata;
      pool_n   = st_q.pool_used;
      st_d     = st_q;

      // one shared tick keeps every bucket on one time base,
      // so rates count bytes per tick, not per clock
      // rate interval counter
      if (st_q.tick_cnt == TCW'(pqs_pkg::TICK_CYC - 1)) begin
         st_d.tick_cnt = '0;
         tick          = 1'b1;
      end else begin
         st_d.tick_cnt = st_q.tick_cnt + 1'b1;
      end

      // strict conformance: the whole length must be in tokens,
      // nothing is borrowed against later ticks
      // head view and conformance of each input
      for (int i = 0; i < NUM_IN; i++) begin
         hlen[i]   = st_q.mem[i][st_q.rp[i]].len;
         ne[i]     = (st_q.cnt[i] != '0);
         min_ok[i] = (st_q.min_tok[i] >= TW'(hlen[i]));
         max_ok[i] = !nwc || (st_q.max_tok[i] >= TW'(hlen[i]));
      end

      // token buckets grow per interval and saturate at burst
      if (tick) begin
         for (int i = 0; i < NUM_IN; i++) begin
            st_d.min_tok[i] = tok_fill(st_q.min_tok[i], st_q.min_rate[i], st_q.min_burst[i]);
            st_d.max_tok[i] = tok_fill(st_q.max_tok[i], st_q.max_rate[i], st_q.max_burst[i]);
         end
      end

      // refilled on the edge it is taken, so a busy link
      // sees back-to-back packets with no idle cycle
      // output register: held until the link takes it
      if (st_q.ov && out_ready_in) begin
         st_d.ov = 1'b0;
      end
      slot = st_q.ctrl[pqs_pkg::CTRL_EN_BIT] && (!st_q.ov || out_ready_in);

      // an input owed its minimum rate wins before any priority
      // compare; priority only splits what is left over
      // minimum-rate phase first, leftover by priority after it
      req_min  = ne & min_ok & max_ok;
      req_left = ne & max_ok;
      for (int i = 0; i < NUM_IN; i++) begin
         if (req_left[i] && st_q.prio[i] < best) begin
            best = st_q.prio[i];
         end
      end
      for (int i = 0; i < NUM_IN; i++) begin
         req_prio[i] = req_left[i] && (st_q.prio[i] == best);
      end
      if (req_min != '0) begin
         pick     = rr_pick(req_min, st_q.rr_last);
         from_min = 1'b1;
      end else begin
         pick = rr_pick(req_prio, st_q.rr_last);
      end

      // release one packet onto the output when permitted
      if (slot && pick[IW]) begin
         si           = pick[IW-1:0];
         pop[si]      = 1'b1;
         st_d.ov      = 1'b1;
         st_d.opkt    = st_q.mem[si][st_q.rp[si]];
         st_d.osrc    = si;
         st_d.rr_last = si;
         if (from_min) begin
            st_d.min_tok[si] = (st_d.min_tok[si] > TW'(hlen[si])) ? st_d.min_tok[si] - TW'(hlen[si]) : '0;
         end
         if (nwc) begin
            st_d.max_tok[si] = (st_d.max_tok[si] > TW'(hlen[si])) ? st_d.max_tok[si] - TW'(hlen[si]) : '0;
         end
      end

      // a drop that meets a pop on the same queue is lost,
      // the dropper must ask again if it still wants it
      // head dropper removes only the head, scheduler has precedence
      for (int i = 0; i < NUM_IN; i++) begin
         if (drop_head_in[i] && ne[i] && !pop[i]) begin
            pop[i] = 1'b1;
         end
      end

      // queue pointers and depth bookkeeping
      for (int i = 0; i < NUM_IN; i++) begin
         if (enq_valid_in[i] && st_q.ready[i]) begin
            st_d.mem[i][st_q.wp[i]] = enq_pkt_in[i];
            st_d.wp[i]  = st_q.wp[i] + 1'b1;
            st_d.cnt[i] = st_d.cnt[i] + 1'b1;
            st_d.byt[i] = st_d.byt[i] + BW'(enq_pkt_in[i].len);
            pool_n      = pool_n + 1'b1;
         end
         if (pop[i]) begin
            st_d.rp[i]  = st_q.rp[i] + 1'b1;
            st_d.cnt[i] = st_d.cnt[i] - 1'b1;
            st_d.byt[i] = st_d.byt[i] - BW'(hlen[i]);
            pool_n      = pool_n - 1'b1;
         end
      end
      st_d.pool_used = pool_n;

      // unmapped offsets miss both decoders: writes are lost
      // and reads return zero
      // register writes
      sel = reg_sel(reg_in.addr);
      if (reg_in.wr) begin
         if (reg_in.addr == pqs_pkg::CTRL_OFS) begin
            st_d.ctrl = wd[1:0];
         end
         if (reg_in.addr == pqs_pkg::POOL_THR_OFS) begin
            st_d.pool_thr = wd[PW-1:0];
         end
         if (sel[IW+5]) begin
            si = sel[IW+4:5];
            unique case (sel[4:0])
               pqs_pkg::MIN_RATE_OFS:  st_d.min_rate[si]  = wd[RW-1:0];
               pqs_pkg::MIN_BURST_OFS: st_d.min_burst[si] = wd[TW-1:0];
               pqs_pkg::MAX_RATE_OFS:  st_d.max_rate[si]  = wd[RW-1:0];
               pqs_pkg::MAX_BURST_OFS: st_d.max_burst[si] = wd[TW-1:0];
               pqs_pkg::PRIO_OFS:      st_d.prio[si]      = wd[PRW-1:0];
               pqs_pkg::DEPTH_THR_OFS: st_d.depth_thr[si] = wd[BW-1:0];
               default: ;
            endcase
         end
      end

      // register reads, answered the cycle after the strobe
      st_d.rdata = '0;
      if (reg_in.rd) begin
         if (reg_in.addr == pqs_pkg::CTRL_OFS) begin
            st_d.rdata = pqs_pkg::DATA_W'(st_q.ctrl);
         end
         if (reg_in.addr == pqs_pkg::POOL_USED_OFS) begin
            st_d.rdata = pqs_pkg::DATA_W'(st_q.pool_used);
         end
         if (reg_in.addr == pqs_pkg::POOL_THR_OFS) begin
            st_d.rdata = pqs_pkg::DATA_W'(st_q.pool_thr);
         end
         if (sel[IW+5]) begin
            si = sel[IW+4:5];
            unique case (sel[4:0])
               pqs_pkg::MIN_RATE_OFS:  st_d.rdata = pqs_pkg::DATA_W'(st_q.min_rate[si]);
               pqs_pkg::MIN_BURST_OFS: st_d.rdata = pqs_pkg::DATA_W'(st_q.min_burst[si]);
               pqs_pkg::MAX_RATE_OFS:  st_d.rdata = pqs_pkg::DATA_W'(st_q.max_rate[si]);
               pqs_pkg::MAX_BURST_OFS: st_d.rdata = pqs_pkg::DATA_W'(st_q.max_burst[si]);
               pqs_pkg::PRIO_OFS:      st_d.rdata = pqs_pkg::DATA_W'(st_q.prio[si]);
               pqs_pkg::DEPTH_THR_OFS: st_d.rdata = pqs_pkg::DATA_W'(st_q.depth_thr[si]);
               pqs_pkg::DEPTH_PKT_OFS: st_d.rdata = pqs_pkg::DATA_W'(st_q.cnt[si]);
               pqs_pkg::DEPTH_BYT_OFS: st_d.rdata = pqs_pkg::DATA_W'(st_q.byt[si]);
               default: ;
            endcase
         end
      end

      // ready keeps room for one packet on every input,
      // so all inputs may enqueue in the same cycle
      // exported status: ready, non-empty, thresholds
      for (int i = 0; i < NUM_IN; i++) begin
         st_d.ready[i]    = (st_d.cnt[i] < (AW+1)'(QDEPTH)) &&
                            (int'(st_d.pool_used) + NUM_IN <= POOL);
         st_d.nonempty[i] = (st_d.cnt[i] != '0);
         st_d.thr[i]      = (st_d.byt[i] > st_d.depth_thr[i]);
      end
      st_d.pthr = (st_d.pool_used >= st_d.pool_thr);
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // reset loads the idle setup: release on, work conserving,
   // no minimum guarantee and an open maximum profile
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         st_q      <= '0;
         st_q.ctrl <= pqs_pkg::CTRL_RST;
         for (int i = 0; i < NUM_IN; i++) begin
            st_q.min_rate[i]  <= pqs_pkg::MIN_RATE_RST;
            st_q.min_burst[i] <= pqs_pkg::MIN_BURST_RST;
            st_q.max_rate[i]  <= pqs_pkg::MAX_RATE_RST;
            st_q.max_burst[i] <= pqs_pkg::MAX_BURST_RST;
            st_q.prio[i]      <= pqs_pkg::PRIO_RST;
         end
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs, all straight from the state register
   // ---------------------------------------------------------------
   assign rd_data_out   = st_q.rdata;
   assign enq_ready_out = st_q.ready;
   assign deq_valid_out = st_q.ov;
   assign deq_pkt_out   = st_q.opkt;
   assign deq_src_out   = st_q.osrc;
   assign nonempty_out  = st_q.nonempty;
   assign depth_pkt_out = st_q.cnt;
   assign depth_byt_out = st_q.byt;
   assign thr_out       = st_q.thr;
   assign pool_thr_out  = st_q.pthr;
endmodule

// [hdl/pqs_pkg.sv]
// constants, field layouts and carrier types of the packet queue scheduler
//
// Contract
// - each queue holds zero or more packets and flags its empty state explicitly
// - enqueue appends an arriving packet at the queue tail
// - dequeue removes the packet standing at the queue head
// - packets leave a queue in exactly their enqueue order
// - queues take packets from upstream inputs and deliver on one output
// - each queue keeps its current depth in packets and in bytes
// - each queue carries a configurable depth threshold reported outward
// - head or side removals never reorder packets of one microflow
// - queues share a limited buffer pool; exhaustion and pool threshold limit depth; only exhaustion gates enqueue here, the threshold sets pool_thr_out
// - each queue exports current depth and threshold triggers to droppers
// - a non-empty indication goes downstream whenever a queue holds a packet
// - scheduler releases packets onto one output only when the discipline permits
// - every scheduler input has its own upstream queue and parameter set
// - discipline uses per-input priority, token-bucket limits, packet length, local state
// - non-work-conserving mode holds a packet until its profile finds it conforming
// - per-input minimum rate profile guarantees that input a minimum rate
// - priority shares leftover bandwidth only after all minimum rates are met
// - maximum rate profile acts only in non-work-conserving mode
// - each rate profile is a rate per time unit plus a burst size
// - equal priorities meet every minimum rate when their sum fits line rate
// - token counters grow at the configured rate and saturate at burst size
// - a packet conforms only when tokens are at least its length
package pqs_pkg;

   // ---------------------------------------------------------------
   // widths and timing
   // ---------------------------------------------------------------
   localparam int LEN_W         = 16;   // packet length in bytes
   localparam int CP_W          = 6;    // codepoint carried with a packet
   localparam int TOK_W         = 24;   // token bucket width, bytes
   localparam int RATE_W        = 16;   // bytes added per rate interval
   localparam int PRIO_W        = 4;
   localparam int ADDR_W        = 8;
   localparam int DATA_W        = 32;
   localparam int CLK_PERIOD_NS = 25;   // 40 MHz system clock
   localparam int TICK_NS       = 1000; // rate interval of every profile
   localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'h00;
   localparam logic [ADDR_W-1:0] POOL_USED_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] POOL_THR_OFS  = 8'h08;
   localparam logic [ADDR_W-1:0] IN_BASE_OFS   = 8'h40; // first per-input block
   localparam logic [ADDR_W-1:0] IN_STRIDE     = 8'h20;
   localparam logic [4:0] MIN_RATE_OFS  = 5'h00;
   localparam logic [4:0] MIN_BURST_OFS = 5'h04;
   localparam logic [4:0] MAX_RATE_OFS  = 5'h08;
   localparam logic [4:0] MAX_BURST_OFS = 5'h0C;
   localparam logic [4:0] PRIO_OFS      = 5'h10;
   localparam logic [4:0] DEPTH_THR_OFS = 5'h14;
   localparam logic [4:0] DEPTH_PKT_OFS = 5'h18;
   localparam logic [4:0] DEPTH_BYT_OFS = 5'h1C;
   localparam int CTRL_EN_BIT  = 0;     // scheduler release enable
   localparam int CTRL_NWC_BIT = 1;     // non-work-conserving discipline

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [1:0]        CTRL_RST      = 2'h1;
   localparam logic [RATE_W-1:0] MIN_RATE_RST  = 16'h0000;
   localparam logic [TOK_W-1:0]  MIN_BURST_RST = 24'h000000;
   localparam logic [RATE_W-1:0] MAX_RATE_RST  = 16'hFFFF;
   localparam logic [TOK_W-1:0]  MAX_BURST_RST = 24'hFFFFFF;
   localparam logic [PRIO_W-1:0] PRIO_RST      = 4'h0;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [CP_W-1:0]  cp;
      logic [LEN_W-1:0] len;
   } pqs_pkt_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pqs_reg_req_t;

endpackage

// [dv/pqs_top_asserts.sv]
// port checker of the packet queue scheduler
`timescale 1ns/10ps
module pqs_chk #(
   parameter int NUM_IN = 2,  // inputs
   parameter int QDEPTH = 16  // slots
) (
   input wire logic                      sys_clk_in,    // clock
   input wire logic                      srst_in,       // reset
   input wire pqs_pkg::pqs_reg_req_t     reg_in,        // request
   input wire logic [pqs_pkg::DATA_W-1:0] rd_data_out,  // read data
   input wire logic [NUM_IN-1:0]         enq_valid_in,  // enqueue
   input wire logic [NUM_IN-1:0]         enq_ready_out, // accept
   input wire logic                      deq_valid_out, // offer
   input wire pqs_pkg::pqs_pkt_t         deq_pkt_out,   // packet
   input wire logic [$clog2(NUM_IN)-1:0] deq_src_out,   // source
   input wire logic                      out_ready_in,  // link ready
   input wire logic [NUM_IN-1:0]         nonempty_out,  // not empty
   input wire logic [NUM_IN-1:0][$clog2(QDEPTH):0] depth_pkt_out, // packets
   input wire logic [NUM_IN-1:0][pqs_pkg::LEN_W+$clog2(QDEPTH):0] depth_byt_out // bytes
);
   logic [NUM_IN-1:0] ne_q;   // nonempty one cycle back
   logic              hold_q; // offer stalled last cycle
   // last cycle's flags tell a fresh pick from a held one
   always_ff @(posedge sys_clk_in) begin
      ne_q   <= nonempty_out;
      hold_q <= deq_valid_out && !out_ready_in;
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   property p_ne; nonempty_out[0] == (depth_pkt_out[0] != '0); endproperty
   a_ne: assert property (p_ne) else $error("nonempty flag wrong");
   property p_hold; deq_valid_out && !out_ready_in |=>
      deq_valid_out && $stable(deq_pkt_out) && $stable(deq_src_out); endproperty
   a_hold: assert property (p_hold) else $error("offer not held");
   property p_pick; deq_valid_out && !hold_q |-> ne_q[deq_src_out]; endproperty
   a_pick: assert property (p_pick) else $error("empty input picked");
   property p_enq; enq_valid_in[0] && enq_ready_out[0] |=>
      nonempty_out[0] && depth_pkt_out[0] >= $past(depth_pkt_out[0]); endproperty
   a_enq: assert property (p_enq) else $error("enqueue lost");
   property p_refuse; enq_valid_in[0] && !enq_ready_out[0] |=>
      depth_pkt_out[0] <= $past(depth_pkt_out[0]); endproperty
   a_refuse: assert property (p_refuse) else $error("refused packet stored");
   property p_byt; depth_pkt_out[0] == '0 |-> depth_byt_out[0] == '0; endproperty
   a_byt: assert property (p_byt) else $error("bytes without packets");
   property p_rd; !reg_in.rd |=> rd_data_out == '0; endproperty
   a_rd: assert property (p_rd) else $error("read data without read");
   property p_rst; $fell(srst_in) |=> enq_ready_out == '1; endproperty
   a_rst: assert property (p_rst) else $error("not ready after reset");
endmodule
bind pqs_top pqs_chk #(.NUM_IN(NUM_IN), .QDEPTH(QDEPTH)) chk_u (.sys_clk_in, .srst_in, .reg_in,
   .rd_data_out, .enq_valid_in, .enq_ready_out, .deq_valid_out, .deq_pkt_out, .deq_src_out,
   .out_ready_in, .nonempty_out, .depth_pkt_out, .depth_byt_out);

// [dv/pqs_link_model.sv]
// downstream link model that logs departures and stalls on command
`timescale 1ns/10ps
module pqs_link_model (
   input  wire logic              clk_in,   // clock
   input  wire logic              stall_in, // hold off departures
   input  wire logic              valid_in, // packet offered
   input  wire pqs_pkg::pqs_pkt_t pkt_in,   // offered packet
   input  wire logic              src_in,   // source input
   output logic                   ready_out // link takes packet
);
   pqs_pkg::pqs_pkt_t got_q[$]; // packets in arrival order
   logic              src_q[$]; // their sources
   initial ready_out = 1'b0;
   // log transfers, follow the stall command one edge later
   always @(posedge clk_in) begin
      if (valid_in && ready_out) begin
         got_q.push_back(pkt_in);
         src_q.push_back(src_in);
      end
      ready_out <= !stall_in;
   end
endmodule

// [dv/tb_top.sv]
// self-checking bench of the packet queue scheduler
`timescale 1ns/10ps
module tb_top;
   logic                     clk, rst, stall, ordy, dv, src, pthr;
   logic [1:0]               ev, drop, ne, erdy, thr;
   logic [31:0]              rdd;
   pqs_pkg::pqs_reg_req_t    rq;
   pqs_pkg::pqs_pkt_t [1:0]  ep;
   pqs_pkg::pqs_pkt_t        dp;
   int                       errors, samples_checked, cyc;
   logic [39:0]              rows [12] = '{40'h0000000001, 40'h0400000000, 40'h0800000000,
      40'h4000000000, 40'h4400000000, 40'h4800000010, 40'h4C00000020, 40'h5000000000,
      40'h680000FFFF, 40'h6C00FFFFFF, 40'h3C00000000, 40'h5800000000};
   pqs_top #(.NUM_IN(2), .QDEPTH(16), .POOL(8)) dut_u (.sys_clk_in(clk), .srst_in(rst), .reg_in(rq),
      .rd_data_out(rdd), .enq_valid_in(ev), .enq_pkt_in(ep), .enq_ready_out(erdy), .drop_head_in(drop),
      .deq_valid_out(dv), .deq_pkt_out(dp), .deq_src_out(src), .out_ready_in(ordy), .nonempty_out(ne),
      .depth_pkt_out(), .depth_byt_out(), .thr_out(thr), .pool_thr_out(pthr));
   pqs_link_model link_u (.clk_in(clk), .stall_in(stall), .valid_in(dv), .pkt_in(dp), .src_in(src),
      .ready_out(ordy));
   // clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // cycle ceiling
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         $display("CHECK FAILED %0t timeout", $time);
         end_of_test();
      end
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      rq <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      rq <= '0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk);
      rq <= '0;
      @(negedge clk);
      cmp(rdd, e);
      @(posedge clk);
   endtask
   task automatic enq(input int i, input logic [15:0] len);
      ev[i] <= 1'b1;
      ep[i] <= '{6'h2A, len};
      @(posedge clk);
      ev[i] <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_got(input int n, input int lim);
      for (int k = 0; k < lim && link_u.got_q.size() < n; k++) @(posedge clk);
      cmp(link_u.got_q.size(), n);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      rst = 1'b1;
      rq = '0;
      ev = '0;
      ep = '0;
      drop = '0;
      stall = 1'b0;
      cyc = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wr(8'h48, 32'h10);
      wr(8'h4C, 32'h20);
      foreach (rows[k]) rd(rows[k][39:32], rows[k][31:0]);
      $display("register table done");
      wr(8'h00, 32'h0);
      wr(8'h70, 32'h1);
      wr(8'h54, 32'h64);
      wr(8'h08, 32'h7);
      for (int k = 1; k <= 4; k++) enq(0, 16'(10 * k));
      for (int k = 5; k <= 7; k++) enq(1, 16'(10 * k));
      rd(8'h04, 32'h7);
      cmp(erdy, 2'h0);
      cmp(pthr, 1'b1);
      enq(0, 16'h0050);
      drop[1] <= 1'b1;
      @(posedge clk);
      drop[1] <= 1'b0;
      @(posedge clk);
      rd(8'h04, 32'h6);
      cmp(pthr, 1'b0);
      cmp(erdy, 2'h3);
      rd(8'h58, 32'h4);
      rd(8'h5C, 32'h64);
      rd(8'h78, 32'h2);
      cmp(ne, 2'h3);
      cmp(thr, 2'h2);
      stall <= 1'b1;
      wr(8'h00, 32'h1);
      repeat (5) @(posedge clk);
      cmp(dv, 1'b1);
      cmp(dp.len, 16'h000A);
      stall <= 1'b0;
      wait_got(6, 60);
      for (int k = 0; k < 6; k++) begin
         cmp(link_u.got_q[k].len, (k < 4) ? 10 * k + 10 : 10 * k + 20);
         cmp(link_u.src_q[k], k > 3);
      end
      $display("order and priority done");
      wr(8'h00, 32'h3);
      enq(0, 16'h0020);
      enq(0, 16'h0020);
      enq(0, 16'h0021);
      wait_got(7, 20);
      repeat (30) @(posedge clk);
      cmp(link_u.got_q.size(), 7);
      wait_got(8, 100);
      repeat (200) @(posedge clk);
      cmp(link_u.got_q.size(), 8);
      cmp(ne[0], 1'b1);
      wr(8'h00, 32'h1);
      wait_got(9, 20);
      cmp(link_u.got_q[8].len, 16'h0021);
      $display("rate profile done");
      end_of_test();
   end
endmodule
